// ### core/coef_store.sv
// Coefficient store: one write port, one registered read port
module coef_store
  import vld_payload_pkg::*;
(
  // Clock
  input wire logic mclk_i,
  // Write side
  input wire logic wr_en_i,
  input wire logic [MEM_AW-1:0] wr_addr_i,
  input wire logic [15:0] wr_data_i,
  // Read side
  input wire logic [MEM_AW-1:0] rd_addr_i,
  output logic [15:0] rd_data_o
);
  logic [15:0] mem [MEM_DEPTH];

  // Storage holds no reset; contents are always rewritten before use
  always_ff @(posedge mclk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Read data leaves from a flop one cycle after the address
  always_ff @(posedge mclk_i) begin
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

// ### core/vld_payload_framer.sv
// Framer of the decode-mode root thread payload for the register file
// Functional notes
// - Params follow header; with push constants they follow the constants.
// - Header dword five low byte carries the spawner's thread slot id.
// - Header dword four: binding table pointer 31:5, low bits zero.
// - Header dword two: interface descriptor pointer 31:5, low bits zero.
// - Header dword zero and one are all zero in this mode.
// - Param dwords four to seven: motion vectors, vertical high half.
// - Param dword three 26:20: next vertical origin, limited to 120.
// - Param dword three 10:4: next horizontal origin; 19:11 zero.
// - Param dword two 19:18: picture coding type.
// - Param dword two 17:16: picture structure.
// - Param dword two 14:13: intra DC precision.
// - Param dword two bit 12: skip mismatch control.
// - Param dword two 11:6: coded block mask, luma zero at bit 11.
// - Param dword two bit 5: quantizer scale type.
// - Param dword two 4:0: quantizer scale code.
// - Param dword zero 31:28: vertical field select array.
// - Param dword zero 25:24: motion type.
// - Param dword zero bit 21: transform type, zero when mask empty.
// - Param dword zero bits 18 and 17: backward and forward motion.
// - Param dword zero bit 16: intra macroblock flag.
// - Coefficients of coded blocks only, four registers per block.
// - Even row in words 0-7, odd row in words 8-15.
module vld_payload_framer
  import vld_payload_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Macroblock parameters from the decode engine
  input wire logic mb_valid_i,
  input wire mb_params_s mb_params_i,
  input wire logic [7:0] spawned_thread_slot_id_i,
  output logic mb_ready_o,
  // Coefficient stream, coded blocks only, row-major
  input wire logic coef_valid_i,
  input wire logic [15:0] coef_i,
  output logic coef_ready_o,
  // Register file writes toward the spawner
  output logic rf_valid_o,
  output rf_write_s rf_write_o,
  input wire logic rf_ready_i
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_COLLECT, ST_HDR, ST_PARAM, ST_FETCH, ST_SEND
  } state_e;

  state_e state;
  logic [31:0] ctrl;
  logic [31:0] idesc_ptr;
  logic [31:0] bind_ptr;
  logic [7:0] sent_count;
  mb_params_s mb;
  logic [7:0] slot_id;
  logic [MEM_AW-1:0] coef_total;
  logic [MEM_AW-1:0] wr_addr;
  logic [MEM_AW-1:0] rd_addr;
  logic [4:0] fetch_cnt;
  logic [7:0] out_index;
  logic [REG_W-1:0] assembly;
  logic [15:0] rd_data;
  logic [31:0] next_prdata;
  logic next_slverr;
  logic setup;
  logic write_acc;
  logic push_en;
  logic [CTRL_CNT_W-1:0] const_cnt;
  logic [7:0] param_index;
  logic [2:0] block_count;
  logic [REG_W-1:0] hdr_reg;
  logic [REG_W-1:0] param_reg;
  logic [5:0] mask_eff;
  logic [6:0] vert_lim;

  // Registers answer in the first access cycle
  assign pready_o = 1'b1;
  assign setup = psel_i && !penable_i;
  assign write_acc = psel_i && penable_i && pwrite_i;
  assign push_en = ctrl[CTRL_PUSH_BIT];
  assign const_cnt = ctrl[CTRL_CNT_LSB +: CTRL_CNT_W];

  // Read mux, sampled at setup so read data comes out of a flop
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (paddr_i)
      CTRL_OFS: next_prdata = ctrl;
      IDESC_OFS: next_prdata = idesc_ptr;
      BIND_OFS: next_prdata = bind_ptr;
      STATUS_OFS: begin
        next_prdata[STAT_BUSY_BIT] = (state != ST_IDLE);
        next_prdata[STAT_CNT_LSB +: 8] = sent_count;
      end
      default: next_slverr = 1'b1;
    endcase
  end

  // Read data and error answer, held through the access cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o <= pwrite_i ? 32'h0000_0000 : next_prdata;
      pslverr_o <= next_slverr;
    end
  end

  // Control: push-constant enable and constant register count
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctrl <= CTRL_RST;
    end else if (write_acc && paddr_i == CTRL_OFS) begin
      ctrl <= '0;
      ctrl[CTRL_PUSH_BIT] <= pwdata_i[CTRL_PUSH_BIT];
      ctrl[CTRL_CNT_LSB +: CTRL_CNT_W] <=
        pwdata_i[CTRL_CNT_LSB +: CTRL_CNT_W];
    end
  end

  // Pointers keep alignment by writing their low five bits as zero
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      idesc_ptr <= PTR_RST;
      bind_ptr <= PTR_RST;
    end else if (write_acc) begin
      if (paddr_i == IDESC_OFS) begin
        idesc_ptr <= {pwdata_i[31:PTR_LSB], 5'h00};
      end
      if (paddr_i == BIND_OFS) begin
        bind_ptr <= {pwdata_i[31:PTR_LSB], 5'h00};
      end
    end
  end

  // Number of coded blocks; only these carry coefficients
  always_comb begin
    block_count = 3'h0;
    for (int i = 0; i < BLOCKS; i++) begin
      block_count = block_count + {2'h0, mb_params_i.coded_mask[i]};
    end
  end

  // Parameter register placed after header, or after the constants
  assign param_index = push_en ? PARAM_BASE + {4'h0, const_cnt}
                               : PARAM_BASE;

  // Header register; unused and reserved dwords stay zero
  always_comb begin
    hdr_reg = '0;
    hdr_reg[2*DW_W +: DW_W] = idesc_ptr;
    hdr_reg[4*DW_W +: DW_W] = bind_ptr;
    hdr_reg[5*DW_W +: 8] = slot_id;
  end

  // Transform type is meaningless without coded blocks
  assign mask_eff = mb.coded_mask;
  // Vertical origin beyond the last legal row is clipped
  assign vert_lim = (mb.next_vert > MAX_VERT) ? MAX_VERT : mb.next_vert;

  // Macroblock parameter register
  always_comb begin
    param_reg = '0;
    param_reg[31:28] = mb.vertical_field_select_array;
    param_reg[25:24] = mb.motion_kind_field;
    param_reg[21] = (mask_eff == 6'h00) ? frame_transform_type
                                        : mb.transform_type;
    param_reg[18] = mb.motion_bwd;
    param_reg[17] = mb.motion_fwd;
    param_reg[16] = mb.intra_mb;
    param_reg[64+19 -: 2] = mb.pic_coding;
    param_reg[64+17 -: 2] = mb.pic_structure;
    param_reg[64+14 -: 2] = mb.dc_precision;
    param_reg[64+12] = mb.no_mismatch;
    param_reg[64+11 -: 6] = mask_eff;
    param_reg[64+5] = mb.quant_type;
    param_reg[64+4 -: 5] = mb.quant_code;
    param_reg[96+26 -: 7] = vert_lim;
    param_reg[96+10 -: 7] = mb.next_horz;
    // Field 0 fwd, field 0 bwd, field 1 fwd, field 1 bwd; vert high
    for (int v = 0; v < 8; v++) begin
      param_reg[128 + 16*v +: 16] = mb.motion_vec[v];
    end
  end

  assign mb_ready_o = (state == ST_IDLE);
  assign coef_ready_o = (state == ST_COLLECT);

  // Payload sequencer
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (mb_valid_i) begin
            state <= (block_count == 3'h0) ? ST_HDR : ST_COLLECT;
          end
        end
        ST_COLLECT: begin
          if (coef_valid_i && wr_addr == coef_total - 9'h001) begin
            state <= ST_HDR;
          end
        end
        ST_HDR: begin
          if (rf_valid_o && rf_ready_i) begin
            state <= ST_PARAM;
          end
        end
        ST_PARAM: begin
          if (rf_valid_o && rf_ready_i) begin
            state <= (coef_total == '0) ? ST_IDLE : ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (fetch_cnt == 5'd16) begin
            state <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (rf_valid_o && rf_ready_i) begin
            state <= (rd_addr == coef_total) ? ST_IDLE : ST_FETCH;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Capture of one macroblock's parameters at acceptance
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mb <= '0;
      slot_id <= 8'h00;
      coef_total <= '0;
    end else if (state == ST_IDLE && mb_valid_i) begin
      mb <= mb_params_i;
      slot_id <= spawned_thread_slot_id_i;
      coef_total <= MEM_AW'({block_count, 6'h00});
    end
  end

  // Coefficient write address; stream lands in arrival order
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_addr <= '0;
    end else if (state == ST_IDLE) begin
      wr_addr <= '0;
    end else if (state == ST_COLLECT && coef_valid_i) begin
      wr_addr <= wr_addr + 9'h001;
    end
  end

  coef_store store (
    .mclk_i(mclk_i),
    .wr_en_i(state == ST_COLLECT && coef_valid_i),
    .wr_addr_i(wr_addr),
    .wr_data_i(coef_i),
    .rd_addr_i(rd_addr),
    .rd_data_o(rd_data)
  );

  // Fetch counter: 16 reads, data lags its address by one cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      fetch_cnt <= 5'd0;
    end else if (state == ST_FETCH) begin
      fetch_cnt <= fetch_cnt + 5'd1;
    end else begin
      fetch_cnt <= 5'd0;
    end
  end

  // Read address walks all coded coefficients once, linearly
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rd_addr <= '0;
    end else if (state == ST_IDLE) begin
      rd_addr <= '0;
    end else if (state == ST_FETCH && fetch_cnt < 5'd16) begin
      rd_addr <= rd_addr + 9'h001;
    end
  end

  // Linear order already puts row 2r in words 0-7, row 2r+1 in 8-15
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      assembly <= '0;
    end else if (state == ST_FETCH && fetch_cnt != 5'd0) begin
      assembly[16*(fetch_cnt - 5'd1) +: 16] <= rd_data;
    end
  end

  // Output register; data and valid are loaded on the same edge, so
  // valid never shows the previous register; one bubble after the header, 18 idle cycles before each coefficient register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rf_valid_o <= 1'b0;
      rf_write_o <= '0;
      out_index <= 8'h00;
    end else if (rf_valid_o) begin
      if (rf_ready_i) begin
        rf_valid_o <= 1'b0;
      end
    end else begin
      case (state)
        ST_HDR: begin
          rf_valid_o <= 1'b1;
          rf_write_o <= '{index: HDR_INDEX, data: hdr_reg};
        end
        ST_PARAM: begin
          rf_valid_o <= 1'b1;
          rf_write_o <= '{index: param_index, data: param_reg};
          out_index <= param_index;
        end
        ST_SEND: begin
          rf_valid_o <= 1'b1;
          rf_write_o <= '{index: out_index + 8'h01, data: assembly};
          out_index <= out_index + 8'h01;
        end
        default: rf_valid_o <= 1'b0;
      endcase
    end
  end

  // Completed payloads, wrapping; lets software watch progress
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sent_count <= 8'h00;
    end else if (rf_ready_i && rf_valid_o && state != ST_HDR &&
                 ((state == ST_PARAM && coef_total == '0) ||
                  (state == ST_SEND && rd_addr == coef_total))) begin
      sent_count <= sent_count + 8'h01;
    end
  end
endmodule

// ### core/vld_payload_pkg.sv
// Constants and carrier types for the decode-mode thread payload framer
package vld_payload_pkg;
  // Register map, byte addresses on the bus
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] IDESC_OFS = 12'h004;
  localparam logic [11:0] BIND_OFS = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00c;
  // Control register fields and reset value
  localparam int CTRL_PUSH_BIT = 1;
  localparam int CTRL_CNT_LSB = 4;
  localparam int CTRL_CNT_W = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CNT_LSB = 8;
  // Pointer alignment: 32-byte, low five bits forced clear
  localparam int PTR_LSB = 5;
  localparam logic [31:0] PTR_RST = 32'h0000_0000;
  // Payload geometry
  localparam int DW_W = 32;
  localparam int REG_W = 256;
  localparam int WORDS_PER_REG = 16;
  localparam int BLOCKS = 6;
  localparam int COEFS_PER_BLOCK = 64;
  localparam int MEM_DEPTH = BLOCKS * COEFS_PER_BLOCK;
  localparam int MEM_AW = 9;
  localparam logic [7:0] HDR_INDEX = 8'h00;
  localparam logic [7:0] PARAM_BASE = 8'h01;
  localparam logic [6:0] MAX_VERT = 7'h78;
  // Picture codes; all-zero coding and structure values are reserved
  localparam logic [1:0] intra_picture_code = 2'h1;
  localparam logic [1:0] predicted_picture_code = 2'h2;
  localparam logic [1:0] bidir_picture_code = 2'h3;
  localparam logic [1:0] top_field_structure = 2'h1;
  localparam logic [1:0] bottom_field_structure = 2'h2;
  localparam logic [1:0] frame_structure = 2'h3;
  localparam logic linear_quant_scale = 1'b0;
  localparam logic nonlinear_quant_scale = 1'b1;
  localparam logic frame_transform_type = 1'b0;
  localparam logic field_transform_type = 1'b1;

  // Macroblock description handed over by the decode engine
  typedef struct packed {
    logic [1:0] pic_coding;
    logic [1:0] pic_structure;
    logic [1:0] dc_precision;
    logic no_mismatch;
    logic [5:0] coded_mask;
    logic quant_type;
    logic [4:0] quant_code;
    logic [3:0] vertical_field_select_array;
    logic [1:0] motion_kind_field;
    logic transform_type;
    logic motion_bwd;
    logic motion_fwd;
    logic intra_mb;
    logic [7:0][15:0] motion_vec;
    logic [6:0] next_vert;
    logic [6:0] next_horz;
  } mb_params_s;

  // One register written into the thread register file
  typedef struct packed {
    logic [7:0] index;
    logic [REG_W-1:0] data;
  } rf_write_s;
endpackage

// ### test/rf_sink_model.sv
// Spawner-side model that accepts register file writes
module rf_sink_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Write handshake
  input wire logic rf_valid_i,
  input wire logic stall_i,
  output logic rf_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ready may lead valid, so stale data offered with valid is caught
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rf_ready_o <= 1'b0;
    end else begin
      rf_ready_o <= !stall_i && !(rf_valid_i && rf_ready_o);
    end
  end
endmodule

// ### test/tb_top.sv
// Self-checking bench for the decode-mode payload framer
module tb_top
  import vld_payload_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, stall;
  logic mb_valid, mb_ready, coef_valid, coef_ready, rf_valid, rf_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] coef;
  logic [7:0] slot_id;
  mb_params_s mb_params;
  rf_write_s rf_write, ew;
  rf_write_s exp_q[$];
  int num_errors = 0;
  int comparisons = 0;

  vld_payload_framer dut (.mclk_i(mclk), .sys_rst_i(sys_rst),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .mb_valid_i(mb_valid),
    .mb_params_i(mb_params), .spawned_thread_slot_id_i(slot_id),
    .mb_ready_o(mb_ready), .coef_valid_i(coef_valid), .coef_i(coef),
    .coef_ready_o(coef_ready), .rf_valid_o(rf_valid),
    .rf_write_o(rf_write), .rf_ready_i(rf_ready));
  rf_sink_model sink (.mclk_i(mclk), .sys_rst_i(sys_rst),
    .rf_valid_i(rf_valid), .stall_i(stall), .rf_ready_o(rf_ready));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [263:0] got, input logic [263:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Bounded wait for a handshake flag sampled at the edge
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (s !== 1'b1 && n < 500);
    if (s !== 1'b1) begin
      num_errors++;
      test_done();
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [32:0] re);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    wait_hi(pready);
    re = {prdata, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Random stalls on the spawner side
  always @(posedge mclk) stall <= ($urandom % 3 == 0);

  // Every register taken must match the next one expected
  always @(posedge mclk) begin
    if (!sys_rst && rf_valid === 1'b1 && rf_ready === 1'b1) begin
      if (exp_q.size() == 0) check(rf_write, 'x);
      else begin
        ew = exp_q.pop_front();
        check(rf_write, ew);
      end
    end
  end

  // Watchdog
  initial begin
    repeat (40000) @(posedge mclk);
    num_errors++;
    test_done();
  end

  initial begin
    mb_params_s m;
    logic [32:0] re;
    logic [31:0] ctrl, idesc, bnd;
    logic [191:0] rnd;
    logic [255:0] d;
    logic [7:0] idx, slot;
    {psel, penable, pwrite, paddr, pwdata, stall} = '0;
    {mb_valid, mb_params, slot_id, coef_valid, coef} = '0;
    sys_rst = 1'b1;
    void'($urandom(40));
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    apb(0, CTRL_OFS, 0, re);
    check(re, {CTRL_RST, 1'b0});
    apb(0, IDESC_OFS, 0, re);
    check(re, {PTR_RST, 1'b0});
    apb(0, 12'h010, 0, re);
    check(re, 33'h1);
    apb(1, BIND_OFS, 32'hffff_ffff, re);
    apb(0, BIND_OFS, 0, re);
    check(re, {32'hffff_ffe0, 1'b0});
    ctrl = '0;
    for (int i = 0; i < 14; i++) begin
      rnd = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      m = rnd[$bits(mb_params_s)-1:0];
      if (m.pic_coding == 2'h0) m.pic_coding = bidir_picture_code;
      if (m.pic_structure == 2'h0) m.pic_structure = frame_structure;
      if (m.motion_kind_field == 2'h0) m.motion_kind_field = 2'h2;
      if (i == 0) m.coded_mask = 6'h00;
      if (i == 1) m.coded_mask = 6'h3f;
      if (i == 1) m.next_vert = 7'h7f;
      if (i == 2) m.next_vert = MAX_VERT;
      if (i == 5) ctrl = 32'h0000_00f2;
      if (i == 10) ctrl = 32'h0000_0002;
      idesc = $urandom;
      bnd = $urandom;
      slot = 8'($urandom);
      apb(1, CTRL_OFS, ctrl, re);
      apb(1, IDESC_OFS, idesc, re);
      apb(1, BIND_OFS, bnd, re);
      d = '0;
      d[95:64] = idesc & 32'hffff_ffe0;
      d[159:128] = bnd & 32'hffff_ffe0;
      d[167:160] = slot;
      exp_q.push_back({HDR_INDEX, d});
      d = '0;
      d[31:28] = m.vertical_field_select_array;
      d[25:24] = m.motion_kind_field;
      d[21] = m.transform_type & (|m.coded_mask);
      d[18:16] = {m.motion_bwd, m.motion_fwd, m.intra_mb};
      d[83:64] = {m.pic_coding, m.pic_structure, 1'b0, m.dc_precision,
        m.no_mismatch, m.coded_mask, m.quant_type, m.quant_code};
      d[122:116] = m.next_vert > MAX_VERT ? MAX_VERT : m.next_vert;
      d[106:100] = m.next_horz;
      d[255:128] = m.motion_vec;
      idx = PARAM_BASE + (ctrl[1] ? {4'h0, ctrl[7:4]} : 8'h00);
      exp_q.push_back({idx, d});
      mb_valid <= 1'b1;
      mb_params <= m;
      slot_id <= slot;
      wait_hi(mb_ready);
      mb_valid <= 1'b0;
      // Coded blocks only, luma zero first, rows in word order
      for (int b = 5; b >= 0; b--) begin
        for (int q = 0; q < 4 && m.coded_mask[b]; q++) begin
          idx++;
          for (int k = 0; k < 16; k++) begin
            d[16*k +: 16] = 16'($urandom);
            coef_valid <= 1'b1;
            coef <= d[16*k +: 16];
            wait_hi(coef_ready);
          end
          exp_q.push_back({idx, d});
        end
      end
      coef_valid <= 1'b0;
      for (int n = 0; n < 3000 && (exp_q.size() != 0 || !mb_ready); n++)
        @(posedge mclk);
      check(exp_q.size(), 0);
    end
    repeat (4) @(posedge mclk);
    apb(0, STATUS_OFS, 0, re);
    check({re[16:9], re[1]}, {8'd14, 1'b0});
    test_done();
  end
endmodule

// ### test/vld_payload_assertions.sv
// Port checker for the decode-mode payload framer
module vld_payload_assertions
  import vld_payload_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Bus
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  // Macroblock and coefficient side
  input wire logic mb_valid_i,
  input wire mb_params_s mb_params_i,
  input wire logic [7:0] spawned_thread_slot_id_i,
  input wire logic mb_ready_o,
  input wire logic coef_valid_i,
  input wire logic coef_ready_o,
  // Register file side
  input wire logic rf_valid_o,
  input wire rf_write_s rf_write_o,
  input wire logic rf_ready_i
);
  timeunit 1ns;
  timeprecision 1ps;
  mb_params_s cap;
  logic [7:0] slot;
  logic [7:0] pidx;
  logic [7:0] last;
  logic [7:0] idx;
  logic [255:0] d;
  logic hs;
  logic prm;
  assign idx = rf_write_o.index;
  assign d = rf_write_o.data;
  assign hs = rf_valid_o && rf_ready_i;
  assign prm = hs && idx == pidx;

  // Macroblock as taken; the payload is judged against it
  always_ff @(posedge mclk_i) begin
    if (mb_valid_i && mb_ready_o) begin
      cap <= mb_params_i;
      slot <= spawned_thread_slot_id_i;
    end
  end

  // Param index follows the last control write
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pidx <= PARAM_BASE;
    end else if (psel_i && penable_i && pwrite_i && pready_o
                 && paddr_i == CTRL_OFS) begin
      pidx <= PARAM_BASE + (pwdata_i[CTRL_PUSH_BIT] ?
              {4'h0, pwdata_i[7:4]} : 8'h00);
    end
  end

  // Index of the last register taken; ff means none yet
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      last <= 8'hff;
    end else if (hs) begin
      last <= idx;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  hdr_zero_a: assert property (
    hs && idx == HDR_INDEX |-> d[68:0] == '0 && d[127:96] == '0
    && d[132:128] == '0 && d[255:168] == '0)
    else $error("header reserved bits set");
  slot_id_a: assert property (
    hs && idx == HDR_INDEX |-> d[167:160] == slot)
    else $error("header thread slot wrong");
  reg_order_a: assert property (
    hs && idx != HDR_INDEX && last != 8'hff
    |-> idx == (last == HDR_INDEX ? pidx : last + 8'h01))
    else $error("register index out of order");
  mv_layout_a: assert property (
    prm |-> d[255:128] == cap.motion_vec)
    else $error("motion vectors misplaced");
  origin_a: assert property (
    prm |-> d[122:116] == (cap.next_vert > MAX_VERT ? MAX_VERT :
    cap.next_vert) && d[106:100] == cap.next_horz && d[115:107] == '0)
    else $error("next origin wrong");
  pic_fields_a: assert property (
    prm |-> d[83:80] == {cap.pic_coding, cap.pic_structure}
    && d[78:77] == cap.dc_precision)
    else $error("picture fields wrong");
  quant_mask_a: assert property (
    prm |-> d[76:64] == {cap.no_mismatch, cap.coded_mask,
    cap.quant_type, cap.quant_code})
    else $error("quantizer or mask wrong");
  motion_bits_a: assert property (
    prm |-> d[31:28] == cap.vertical_field_select_array
    && d[25:24] == cap.motion_kind_field
    && d[18:16] == {cap.motion_bwd, cap.motion_fwd, cap.intra_mb})
    else $error("motion control bits wrong");
  transform_a: assert property (
    prm |-> d[21] == (cap.transform_type && |cap.coded_mask))
    else $error("transform type wrong");
  coef_busy_a: assert property (
    coef_valid_i && coef_ready_o |-> !mb_ready_o && !rf_valid_o)
    else $error("coefficient taken while idle");
  mb_busy_a: assert property (
    mb_valid_i && mb_ready_o |=> (!mb_ready_o) [*2])
    else $error("new macroblock taken too soon");
  rf_hold_a: assert property (
    rf_valid_o && !rf_ready_i |=> rf_valid_o && $stable(rf_write_o))
    else $error("register write dropped");
endmodule

bind vld_payload_framer vld_payload_assertions chk (
  .mclk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .pready_o, .mb_valid_i, .mb_params_i,
  .spawned_thread_slot_id_i, .mb_ready_o, .coef_valid_i, .coef_ready_o,
  .rf_valid_o, .rf_write_o, .rf_ready_i
);
